// ===== design/acc_conv_ctrl.sv
/*
 * conversion control of an eight channel 8-bit successive approximation
 * converter: mode, result and clock control registers, sequencer.
 * assumes a register master on the same clock, a comparator pin from
 * the analog front end (asynchronous) and standby levels from the cpu.
 */
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module acc_conv_ctrl
	import acc_pkg::*;
#(
	parameter int unsigned CONV_CYC = acc_pkg::ACC_CONV_CYC
) (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire acc_pkg::acc_bus_req_t busReq,
	output logic                [7:0] rdata,
	input  wire logic                 cmpRaw,
	input  wire logic                 stopMode,
	input  wire logic                 haltMode,
	output acc_pkg::acc_ana_ctl_t     anaCtl
);
	import acc_pkg::*;

	localparam int unsigned STEP_CYC   = CONV_CYC / 9;
	localparam int unsigned SAMPLE_CYC = CONV_CYC - 8 * STEP_CYC;
	localparam int          A_START_MAX = ACC_START_MAX_CYC;

	//////////////////////////////////////////////////////////////////////
	// declarations
	acc_state_t   state_r;
	acc_state_t   state_nxt;
	logic [15:0]  cnt_r;
	logic [15:0]  cnt_nxt;
	logic [2:0]   chanField_r;
	logic [2:0]   chanField_nxt;
	logic         startPend_r;
	logic         startPend_nxt;
	logic         done_r;
	logic         done_nxt;
	logic [7:0]   result_r;
	logic [7:0]   result_nxt;
	logic [7:0]   scc_r;
	logic [7:0]   scc_nxt;
	logic [1:0]   pcc_r;
	logic [1:0]   pcc_nxt;
	logic [7:0]   rdata_r;
	logic [7:0]   rdata_nxt;
	acc_ana_ctl_t anaCtl_r;
	acc_ana_ctl_t anaCtl_nxt;
	logic         cmpS1_r;
	logic         cmpS2_r;
	logic         cmpS3_r;
	logic         cmpLvl_r;
	logic         cmpLvl_nxt;
	logic         halted;
	logic         beginConv;
	logic         stepNow;
	logic         finish;
	logic         modeWr;
	logic [7:0]   sarCode;
	logic [7:0]   sarResolved;
	logic         sarLast;
	logic [15:0]  runCnt_r;

	// register address match
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	//////////////////////////////////////////////////////////////////////
	// comparator pin synchroniser, accepted when stages two and three agree
	always_comb begin
		cmpLvl_nxt = cmpLvl_r;
		if (cmpS2_r == cmpS3_r) begin
			cmpLvl_nxt = cmpS3_r;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cmpS1_r  <= 1'b0;
			cmpS2_r  <= 1'b0;
			cmpS3_r  <= 1'b0;
			cmpLvl_r <= 1'b0;
		end else begin
			cmpS1_r  <= cmpRaw;
			cmpS2_r  <= cmpS1_r;
			cmpS3_r  <= cmpS2_r;
			cmpLvl_r <= cmpLvl_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// sequencer control terms
	always_comb begin
		halted = stopMode | scc_r[ACC_SCC_OSCSTOP_BIT]
			| (haltMode & scc_r[ACC_SCC_SUBCLK_BIT]);
		modeWr    = busReq.wr & hit(busReq.addr, ACC_OFS_MODE);
		beginConv = startPend_r & ~halted;
		stepNow   = (state_r == ACC_BITS) & ~halted
			& (cnt_r == 16'(STEP_CYC - 1));
		finish    = stepNow & sarLast & ~beginConv;
	end

	acc_sar_core #(
		.W       (ACC_RES_BITS)
	) u_sar (
		.clock   (clock),
		.rst     (rst),
		.load    (beginConv),
		.step    (stepNow & ~beginConv),
		.cmpHigh (cmpLvl_r),
		.code    (sarCode),
		.resolved(sarResolved),
		.lastBit (sarLast)
	);

	//////////////////////////////////////////////////////////////////////
	// sequencer: sample phase then eight equal bit steps
	always_comb begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		anaCtl_nxt = anaCtl_r;
		anaCtl_nxt.code = sarCode;
		if (beginConv) begin
			state_nxt         = ACC_SAMPLE;
			cnt_nxt           = '0;
			anaCtl_nxt.chan   = chanField_r;
			anaCtl_nxt.sample = 1'b1;
			anaCtl_nxt.busy   = 1'b1;
		end else if (!halted) begin
			case (state_r)
				ACC_IDLE: begin
					cnt_nxt = '0;
				end
				ACC_SAMPLE: begin
					if (cnt_r == 16'(SAMPLE_CYC - 1)) begin
						state_nxt         = ACC_BITS;
						cnt_nxt           = '0;
						anaCtl_nxt.sample = 1'b0;
					end else begin
						cnt_nxt = cnt_r + 16'h0001;
					end
				end
				ACC_BITS: begin
					if (stepNow) begin
						cnt_nxt = '0;
						if (sarLast) begin
							state_nxt       = ACC_IDLE;
							anaCtl_nxt.busy = 1'b0;
						end
					end else begin
						cnt_nxt = cnt_r + 16'h0001;
					end
				end
				default: begin
					state_nxt = ACC_IDLE;
					cnt_nxt   = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_r  <= ACC_IDLE;
			cnt_r    <= '0;
			anaCtl_r <= '0;
		end else begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			anaCtl_r <= anaCtl_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// software registers; hardware set of done wins over a software clear
	always_comb begin
		chanField_nxt = chanField_r;
		startPend_nxt = startPend_r;
		done_nxt      = done_r;
		result_nxt    = result_r;
		scc_nxt       = scc_r;
		pcc_nxt       = pcc_r;
		if (modeWr) begin
			chanField_nxt = busReq.wdata[ACC_MODE_CH_LSB +: 3];
			startPend_nxt = busReq.wdata[ACC_MODE_START_BIT];
			done_nxt      = busReq.wdata[ACC_MODE_DONE_BIT];
		end else if (beginConv) begin
			startPend_nxt = 1'b0;
		end
		if (beginConv) begin
			done_nxt = 1'b0;
		end else if (finish) begin
			done_nxt   = 1'b1;
			result_nxt = sarResolved;
		end
		if (busReq.wr && hit(busReq.addr, ACC_OFS_SCC)) begin
			scc_nxt = '0;
			scc_nxt[ACC_SCC_OSCSTOP_BIT] = busReq.wdata[ACC_SCC_OSCSTOP_BIT];
			scc_nxt[ACC_SCC_SUBCLK_BIT]  = busReq.wdata[ACC_SCC_SUBCLK_BIT];
		end
		if (busReq.wr && hit(busReq.addr, ACC_OFS_PCC)) begin
			pcc_nxt = busReq.wdata[ACC_PCC_SPEED_LSB +: 2];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			chanField_r <= ACC_MODE_RST[ACC_MODE_CH_LSB +: 3];
			startPend_r <= ACC_MODE_RST[ACC_MODE_START_BIT];
			done_r      <= ACC_MODE_RST[ACC_MODE_DONE_BIT];
			result_r    <= ACC_RES_RST;
			scc_r       <= ACC_SCC_RST;
			pcc_r       <= ACC_PCC_RST[1:0];
		end else begin
			chanField_r <= chanField_nxt;
			startPend_r <= startPend_nxt;
			done_r      <= done_nxt;
			result_r    <= result_nxt;
			scc_r       <= scc_nxt;
			pcc_r       <= pcc_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// read port, data one cycle after the strobe, unmapped reads zero
	always_comb begin
		rdata_nxt = 8'h00;
		if (busReq.rd) begin
			case (busReq.addr)
				ACC_OFS_MODE: begin
					rdata_nxt[ACC_MODE_CH_LSB +: 3]  = chanField_r;
					rdata_nxt[ACC_MODE_START_BIT]    = startPend_r;
					rdata_nxt[ACC_MODE_DONE_BIT]     = done_r;
				end
				ACC_OFS_RES: begin
					rdata_nxt = result_r;
				end
				ACC_OFS_SCC: begin
					rdata_nxt = scc_r;
				end
				ACC_OFS_PCC: begin
					rdata_nxt[ACC_PCC_SPEED_LSB +: 2] = pcc_r;
				end
				default: begin
					rdata_nxt = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata  = rdata_r;
	assign anaCtl = anaCtl_r;

	//////////////////////////////////////////////////////////////////////
	// helper: running cycles since the conversion began
	always_ff @(posedge clock) begin
		if (rst) begin
			runCnt_r <= '0;
		end else if (beginConv) begin
			runCnt_r <= '0;
		end else if (state_r != ACC_IDLE && !halted) begin
			runCnt_r <= runCnt_r + 16'h0001;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_start_begins: assert property (
		(modeWr && busReq.wdata[ACC_MODE_START_BIT] && !halted) ##1 !halted
		|=> (state_r == ACC_SAMPLE) && anaCtl_r.busy && anaCtl_r.sample)
		else $error("start write did not begin a conversion");

	a_start_self_clear: assert property (
		(beginConv && !modeWr) |=> !startPend_r ##1 !startPend_r [*2])
		else $error("start bit not cleared after begin");

	a_done_clear_bound: assert property (
		(modeWr && busReq.wdata[ACC_MODE_START_BIT])
		##1 (!halted && !modeWr) [*2]
		|-> ##[0:A_START_MAX] !done_r)
		else $error("done flag not cleared after start");

	a_conv_length: assert property (
		finish |-> (runCnt_r == 16'(CONV_CYC - 1)))
		else $error("conversion length wrong");

	a_done_and_result: assert property (
		finish |=> done_r && (result_r == $past(sarResolved)) && !anaCtl_r.busy)
		else $error("completion did not set done and result");

	a_result_wr_ignored: assert property (
		(busReq.wr && hit(busReq.addr, ACC_OFS_RES) && !finish) |=> $stable(result_r))
		else $error("result register changed on write");

	a_result_hold: assert property (
		(!finish) |=> $stable(result_r))
		else $error("result changed without completion");

	a_halt_freeze: assert property (
		(halted && !beginConv && state_r != ACC_IDLE)
		|=> $stable(cnt_r) && $stable(state_r) && $stable(sarCode))
		else $error("sequencer moved while halted");

	a_chan_latch: assert property (
		beginConv |=> (anaCtl_r.chan == $past(chanField_r)))
		else $error("channel not taken at begin");

	a_msb_first: assert property (
		beginConv |=> (sarCode == 8'h80) ##1 (state_r != ACC_BITS) [*1])
		else $error("first trial not msb");

	a_bits_kept: assert property (
		(state_r == ACC_BITS && !stepNow && !beginConv) |=> $stable(sarCode))
		else $error("trial code moved between steps");

	a_reset_values: assert property (
		$past(rst) |-> (rdata_r == 8'h00) && done_r && !startPend_r
		&& (chanField_r == 3'h0) && (result_r == 8'h7F))
		else $error("reset values wrong");

endmodule

// ===== design/acc_pkg.sv
/*
 * constants and carrier types of the conversion control block.
 * assumes one 20 MHz clock that also serves as the converter clock.
 */
package acc_pkg;

	//////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned ACC_CLK_PERIOD_NS = 50;
	localparam int unsigned ACC_CONV_TIME_NS  = 28000;
	// conversion length, exact division
	localparam int unsigned ACC_CONV_CYC      = ACC_CONV_TIME_NS / ACC_CLK_PERIOD_NS;
	localparam int unsigned ACC_START_MAX_NS  = 2670;
	// longest start delay, rounded down
	localparam int unsigned ACC_START_MAX_CYC = ACC_START_MAX_NS / ACC_CLK_PERIOD_NS;
	localparam int unsigned ACC_RES_BITS      = 8;

	//////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [3:0] ACC_OFS_MODE = 4'h0;
	localparam logic [3:0] ACC_OFS_RES  = 4'h1;
	localparam logic [3:0] ACC_OFS_SCC  = 4'h2;
	localparam logic [3:0] ACC_OFS_PCC  = 4'h3;

	// field positions
	localparam int unsigned ACC_MODE_CH_LSB     = 4;
	localparam int unsigned ACC_MODE_START_BIT  = 3;
	localparam int unsigned ACC_MODE_DONE_BIT   = 2;
	localparam int unsigned ACC_SCC_OSCSTOP_BIT = 3;
	localparam int unsigned ACC_SCC_SUBCLK_BIT  = 0;
	localparam int unsigned ACC_PCC_SPEED_LSB   = 0;

	// reset values
	localparam logic [7:0] ACC_MODE_RST = 8'h04;
	localparam logic [7:0] ACC_RES_RST  = 8'h7F;
	localparam logic [7:0] ACC_SCC_RST  = 8'h00;
	localparam logic [7:0] ACC_PCC_RST  = 8'h00;

	//////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} acc_bus_req_t;

	typedef struct packed {
		logic [2:0] chan;
		logic [7:0] code;
		logic       sample;
		logic       busy;
	} acc_ana_ctl_t;

	typedef enum logic [1:0] {
		ACC_IDLE   = 2'b00,
		ACC_SAMPLE = 2'b01,
		ACC_BITS   = 2'b10
	} acc_state_t;

endpackage

// ===== design/acc_sar_core.sv
/*
 * successive approximation register: trial code and bit pointer.
 * assumes load and step are never high together and come from the
 * same clock domain; cmpHigh is already synchronised.
 */
`timescale 1ns/10ps
module acc_sar_core #(
	parameter int unsigned W = 8
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic         step,
	input  wire logic         cmpHigh,
	output logic      [W-1:0] code,
	output logic      [W-1:0] resolved,
	output logic              lastBit
);

	logic [W-1:0] code_r;
	logic [W-1:0] code_nxt;
	logic [W-1:0] mask_r;
	logic [W-1:0] mask_nxt;

	// current bit kept when input is at or above the trial
	always_comb begin
		resolved = cmpHigh ? code_r : (code_r & ~mask_r);
		lastBit  = mask_r[0];
		code     = code_r;
	end

	// msb first, decided bits never touched again
	always_comb begin
		code_nxt = code_r;
		mask_nxt = mask_r;
		if (load) begin
			mask_nxt = {1'b1, {(W-1){1'b0}}};
			code_nxt = {1'b1, {(W-1){1'b0}}};
		end else if (step) begin
			mask_nxt = mask_r >> 1;
			code_nxt = resolved | (mask_r >> 1);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			code_r <= '0;
			mask_r <= '0;
		end else begin
			code_r <= code_nxt;
			mask_r <= mask_nxt;
		end
	end

endmodule

// ===== test/acc_ana_model.sv
/*
 * analog channel model: eight fixed input levels and one comparator.
 * assumes the trial code and channel come from the conversion control block.
 */
`timescale 1ns/10ps
module acc_ana_model (
	input  wire acc_pkg::acc_ana_ctl_t anaCtl,
	input  wire logic [7:0][7:0]       levels,
	output logic                       cmpRaw
);
	import acc_pkg::*;

	// high when the selected input is at or above the trial code
	assign cmpRaw = levels[anaCtl.chan] >= anaCtl.code;
endmodule

// ===== test/acc_conv_ctrl_tb.sv
/*
 * self-checking bench of the conversion control block.
 * assumes the analog channel model and a shortened conversion length.
 */
`timescale 1ns/10ps
module acc_conv_ctrl_tb;
	import acc_pkg::*;
	typedef struct packed {
		logic [2:0] ch;
		logic [7:0] lvl;
	} acc_row_t;
	// a length whose seven-cycle bit step outlasts the comparator synchroniser (six cycles, from length 54, would already do)
	localparam int CONV = 63;
	logic                  clock;
	logic                  rst;
	acc_bus_req_t          busReq;
	logic            [7:0] rdata;
	logic                  cmpRaw;
	logic                  stopMode;
	logic                  haltMode;
	acc_ana_ctl_t          anaCtl;
	logic       [7:0][7:0] levels;
	acc_row_t              rows [8];
	logic            [7:0] prev;
	int                    err_total;
	int                    checks;

	//////////////////////////////////////////////////////////////////////
	// design and analog side
	acc_conv_ctrl #(.CONV_CYC(CONV)) DUT (
		.clock(clock), .rst(rst), .busReq(busReq), .rdata(rdata),
		.cmpRaw(cmpRaw), .stopMode(stopMode), .haltMode(haltMode), .anaCtl(anaCtl)
	);
	acc_ana_model ANA (.anaCtl(anaCtl), .levels(levels), .cmpRaw(cmpRaw));

	//////////////////////////////////////////////////////////////////////
	// compare, verdict and bus tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		if (err_total == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		busReq.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		busReq.addr <= a;
		busReq.rd <= 1'b1;
		@(posedge clock);
		busReq.rd <= 1'b0;
		#1;
		chk({8'h00, rdata}, {8'h00, e});
	endtask

	// waits for begin, counts busy cycles, halts and reads in mid-run
	task automatic run(input logic [2:0] ch, input logic hs, input logic hh, input int exp);
		int n;
		int c;
		n = 0;
		c = 0;
		while (anaCtl.busy !== 1'b1 && n < 16) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk({15'h0000, anaCtl.busy}, 16'h0001);
		chk({12'h000, anaCtl.chan, anaCtl.sample}, {12'h000, ch, 1'b1});
		while (anaCtl.busy === 1'b1 && c < 400) begin
			@(posedge clock);
			c++;
			busReq.rd <= (c == 20 || c == 25);
			busReq.addr <= (c == 25) ? ACC_OFS_MODE : ACC_OFS_RES;
			stopMode <= hs && c >= 5 && c < 15;
			haltMode <= hh && c >= 5 && c < 15;
			#1;
			if (c == 1) chk({8'h00, anaCtl.code}, 16'h0080);
			if (c == 21) chk({8'h00, rdata}, {8'h00, prev});
			if (c == 26) chk({8'h00, rdata}, {9'h000, ch, 4'h0});
			if (c == 26) chk({15'h0000, anaCtl.sample}, 16'h0000);
		end
		chk(16'(c), 16'(exp));
	endtask

	//////////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		close_out();
	end

	//////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst = 1'b1;
		busReq = '0;
		stopMode = 1'b0;
		haltMode = 1'b0;
		err_total = 0;
		checks = 0;
		prev = 8'h7f;
		rows = '{'{3'h0, 8'h00}, '{3'h1, 8'hff}, '{3'h2, 8'h80}, '{3'h3, 8'h7f},
			'{3'h4, 8'h55}, '{3'h5, 8'haa}, '{3'h6, 8'h01}, '{3'h7, 8'hfe}};
		for (int i = 0; i < 8; i++) begin
			levels[rows[i].ch] = rows[i].lvl;
		end
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk({8'h00, rdata}, 16'h0000);
		rd(ACC_OFS_MODE, 8'h04);
		rd(ACC_OFS_RES, 8'h7f);
		wr(ACC_OFS_RES, 8'h55);
		rd(ACC_OFS_RES, 8'h7f);
		rd(4'hf, 8'h00);
		wr(ACC_OFS_PCC, 8'h03);
		rd(ACC_OFS_PCC, 8'h03);
		// ordinary conversions, one row per channel
		for (int i = 0; i < 8; i++) begin
			wr(ACC_OFS_MODE, {1'b0, rows[i].ch, 4'h8});
			run(rows[i].ch, 1'b0, 1'b0, CONV);
			rd(ACC_OFS_RES, rows[i].lvl);
			rd(ACC_OFS_MODE, {1'b0, rows[i].ch, 4'h4});
			prev = rows[i].lvl;
		end
		// stop, halt on main clock, halt on subclock
		wr(ACC_OFS_MODE, 8'h28);
		run(3'h2, 1'b1, 1'b0, CONV + 10);
		prev = levels[2];
		wr(ACC_OFS_MODE, 8'h28);
		run(3'h2, 1'b0, 1'b1, CONV);
		wr(ACC_OFS_SCC, 8'h01);
		wr(ACC_OFS_MODE, 8'h28);
		run(3'h2, 1'b0, 1'b1, CONV + 10);
		// oscillator stopped: start stays pending
		wr(ACC_OFS_SCC, 8'hff);
		rd(ACC_OFS_SCC, 8'h09);
		wr(ACC_OFS_MODE, 8'h38);
		repeat (20) @(posedge clock);
		#1;
		chk({15'h0000, anaCtl.busy}, 16'h0000);
		wr(ACC_OFS_SCC, 8'h00);
		run(3'h3, 1'b0, 1'b0, CONV);
		rd(ACC_OFS_RES, levels[3]);
		// second reset in the middle of a conversion
		wr(ACC_OFS_MODE, 8'h18);
		repeat (10) @(posedge clock);
		rst <= 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk({15'h0000, anaCtl.busy}, 16'h0000);
		rd(ACC_OFS_MODE, 8'h04);
		rd(ACC_OFS_RES, 8'h7f);
		close_out();
	end
endmodule
